// [bench/ncr_node_cfg_test.sv]
`timescale 1ns/1ns
module ncr_node_cfg_test import ncr_pkg::*;;
  logic              clk_sys;
  logic              rst_b;
  logic              req_valid;
  ncr_req_t          req;
  logic              rsp_valid;
  ncr_rsp_t          rsp;
  logic [BOOT_W-1:0] boot_select_pins;
  logic              pll_lock;
  ncr_pll_t          pll_cfg;
  logic              pll_update;
  logic              tile_reset;
  logic              pll_relocking;
  logic              hdr_one_byte;
  logic              ctl_write_lock;
  logic [15:0]       node_id;
  int                err_count;
  int                check_count;
  int                i;
  logic [31:0]       id_exp;
  localparam logic [7:0] UNM [4] = '{8'h02, 8'h03, 8'h07, 8'hFF};

  ncr_node_cfg DUT (.clk_sys(clk_sys), .rst_b(rst_b),
    .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
    .boot_select_pins(boot_select_pins), .pll_lock(pll_lock),
    .pll_cfg(pll_cfg), .pll_update(pll_update), .tile_reset(tile_reset),
    .pll_relocking(pll_relocking), .hdr_one_byte(hdr_one_byte),
    .ctl_write_lock(ctl_write_lock), .node_id(node_id));

  ncr_pll_model #(.LOCK_CYC(20)) PLL (.clk_sys(clk_sys), .rst_b(rst_b),
    .pll_update(pll_update), .pll_cfg(pll_cfg), .pll_lock(pll_lock));

  always #5 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] n,
                      input logic [31:0] d);
    @(posedge clk_sys);
    req_valid <= 1'h1;
    req       <= '{write: w, num: n, wdata: d};
    @(posedge clk_sys);
    req_valid <= 1'h0;
    #1;
    chk("rsp_valid", 32'h1, 32'(rsp_valid));
  endtask

  task automatic wr(input logic [7:0] n, input logic [31:0] d,
                    input logic ea);
    xfer(1'h1, n, d);
    chk("wr_ack", 32'(ea), 32'(rsp.ack));
  endtask

  task automatic rd(input logic [7:0] n, input logic ea,
                    input logic [31:0] er);
    xfer(1'h0, n, 32'h0);
    chk("rd_ack", 32'(ea), 32'(rsp.ack));
    chk("rdata", er, rsp.rdata);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk_sys          = 1'h0;
    rst_b            = 1'h0;
    req_valid        = 1'h0;
    req              = '0;
    boot_select_pins = 8'hA5;
    err_count        = 0;
    check_count      = 0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'h1;
    repeat (4) @(posedge clk_sys);
    // Reset values
    rd(REG_SW_CFG, 1'h1, 32'h0);
    rd(REG_NODE_IDENT, 1'h1, 32'h0);
    chk("hdr", 32'h0, 32'(hdr_one_byte));
    $display("test reset values done");
    // Identity and description words
    id_exp = {8'h00, 8'hA5, SW_REVISION, SW_VERSION};
    rd(REG_NODE_ID_WORD, 1'h1, id_exp);
    boot_select_pins <= 8'h3C;
    wr(REG_NODE_ID_WORD, 32'hFFFF_FFFF, 1'h0);
    rd(REG_NODE_ID_WORD, 1'h1, id_exp);
    wr(REG_SW_DESC, 32'h0, 1'h0);
    rd(REG_SW_DESC, 1'h1,
       {8'h00, NUM_LINKS, NUM_PROCS_SW, NUM_PROCS_DEV});
    $display("test identity done");
    // Unmapped numbers
    for (i = 0; i < 4; i++) begin
      wr(UNM[i], 32'hFFFF_FFFF, 1'h0);
      rd(UNM[i], 1'h0, 32'h0);
    end
    $display("test unmapped done");
    // Node identifier and reserved bits
    wr(REG_NODE_IDENT, 32'hFFFF_1234, 1'h1);
    rd(REG_NODE_IDENT, 1'h1, 32'h0000_1234);
    chk("node_id", 32'h1234, 32'(node_id));
    $display("test node identifier done");
    // Header mode and PLL write lock
    wr(REG_SW_CFG, 32'h7FFF_FFFF, 1'h1);
    rd(REG_SW_CFG, 1'h1, 32'h0000_0101);
    chk("hdr", 32'h1, 32'(hdr_one_byte));
    wr(REG_PLL_SET, 32'h4000_0A01, 1'h0);
    chk("pll_cfg", 32'h0, 32'(pll_cfg));
    chk("tile_reset", 32'h0, 32'(tile_reset));
    wr(REG_SW_CFG, 32'h0, 1'h1);
    chk("hdr", 32'h0, 32'(hdr_one_byte));
    $display("test switch configuration done");
    // PLL write, no relock wait
    wr(REG_PLL_SET, 32'h7FFF_FFFF, 1'h1);
    chk("pll_update", 32'h1, 32'(pll_update));
    chk("tile_reset", 32'h1, 32'(tile_reset));
    chk("pll_cfg", 32'h739F_FF7F, 32'(pll_cfg));
    chk("out_div", 32'h7, 32'(pll_cfg.out_div));
    chk("fb_mult", 32'h1FFF, 32'(pll_cfg.fb_mult));
    chk("in_div", 32'h7F, 32'(pll_cfg.in_div));
    repeat (TILE_RST_CYC - 1) @(posedge clk_sys);
    #1;
    chk("tile_reset", 32'h1, 32'(tile_reset));
    @(posedge clk_sys);
    #1;
    chk("tile_reset", 32'h0, 32'(tile_reset));
    rd(REG_PLL_SET, 1'h1, 32'h739F_FF7F);
    $display("test pll fast change done");
    // PLL write waiting for relock
    wr(REG_PLL_SET, 32'h0080_0A01, 1'h1);
    chk("bypass", 32'h0, 32'(pll_cfg.bypass));
    chk("jtag_boot", 32'h0, 32'(pll_cfg.jtag_boot));
    chk("out_div", 32'h1, 32'(pll_cfg.out_div));
    chk("fb_mult", 32'h0A, 32'(pll_cfg.fb_mult));
    chk("in_div", 32'h1, 32'(pll_cfg.in_div));
    repeat (TILE_RST_CYC + 4) @(posedge clk_sys);
    #1;
    chk("tile_reset", 32'h1, 32'(tile_reset));
    chk("relocking", 32'h1, 32'(pll_relocking));
    for (i = 0; i < 40 && tile_reset !== 1'h0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (tile_reset !== 1'h0) begin
      chk("relock_wait", 32'h0, 32'(tile_reset));
      end_of_test();
    end
    chk("relocking", 32'h0, 32'(pll_relocking));
    $display("test pll relock done");
    // Settings applied without reset
    wr(REG_PLL_SET, 32'h8000_0003, 1'h1);
    chk("pll_update", 32'h1, 32'(pll_update));
    chk("tile_reset", 32'h0, 32'(tile_reset));
    chk("in_div", 32'h3, 32'(pll_cfg.in_div));
    $display("test pll no reset done");
    // Control write lock
    wr(REG_SW_CFG, 32'h8000_0000, 1'h1);
    chk("ctl_lock", 32'h1, 32'(ctl_write_lock));
    wr(REG_NODE_IDENT, 32'h0000_5555, 1'h0);
    wr(REG_SW_CFG, 32'h0, 1'h0);
    wr(REG_PLL_SET, 32'h0, 1'h0);
    rd(REG_NODE_IDENT, 1'h1, 32'h0000_1234);
    rd(REG_SW_CFG, 1'h1, 32'h8000_0000);
    chk("pll_cfg", 32'h8000_0003, 32'(pll_cfg));
    $display("test control lock done");
    // Reset again in mid-run
    @(posedge clk_sys);
    rst_b <= 1'h0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'h1;
    repeat (4) @(posedge clk_sys);
    rd(REG_SW_CFG, 1'h1, 32'h0);
    rd(REG_PLL_SET, 1'h1, PLL_RST);
    id_exp = {8'h00, 8'h3C, SW_REVISION, SW_VERSION};
    rd(REG_NODE_ID_WORD, 1'h1, id_exp);
    wr(REG_NODE_IDENT, 32'h0000_5555, 1'h1);
    chk("node_id", 32'h5555, 32'(node_id));
    $display("test reset again done");
    end_of_test();
  end
endmodule

// [bench/ncr_pll_model.sv]
`timescale 1ns/1ns
module ncr_pll_model import ncr_pkg::*; #(
  parameter int LOCK_CYC = 20
) (
  // Clock and reset
  input  wire logic     clk_sys,
  input  wire logic     rst_b,
  // Settings from the block
  input  wire logic     pll_update,
  input  wire ncr_pll_t pll_cfg,
  // Lock indication
  output logic          pll_lock
);
  logic [7:0] cnt_r;

  // Loses lock on a new setting unless its no_wait bit is set
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_r    <= 8'h00;
      pll_lock <= 1'h1;
    end else if (pll_update && !pll_cfg.no_wait) begin
      cnt_r    <= 8'(LOCK_CYC);
      pll_lock <= 1'h0;
    end else if (cnt_r != 8'h00) begin
      cnt_r    <= cnt_r - 8'h01;
      pll_lock <= (cnt_r == 8'h01);
    end
  end
endmodule

// [hw/ncr_node_cfg.sv]
// Behaviour
// - Node registers reached only by config requests
// - Identity word holds version and revision
// - Boot pins captured after reset release, read-only after
// - Description reports link and processor counts
// - Control lock bit blocks register writes
// - PLL lock bit rejects PLL writes
// - Header bit selects 2-byte or 1-byte headers
// - Writable 16-bit node identifier, resets zero
// - PLL settings drive the multiplied clock
// - PLL write resets the tile
// - Bit 31 applies settings without reset
// - Bit 30 skips waiting for PLL relock
// - Bit 29 puts PLL in bypass
// - Bit 28 selects boot from JTAG
// - Output divider P in bits 25:23
// - Feedback multiplier M in bits 20:8
// - Input divider N in bits 6:0
`timescale 1ns/1ns
module ncr_node_cfg import ncr_pkg::*; (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // Configuration request
  input  wire logic              req_valid,
  input  wire ncr_req_t          req,
  // Configuration response
  output logic                   rsp_valid,
  output ncr_rsp_t               rsp,
  // Pins and PLL status
  input  wire logic [BOOT_W-1:0] boot_select_pins,
  input  wire logic              pll_lock,
  // Node controls
  output ncr_pll_t               pll_cfg,
  output logic                   pll_update,
  output logic                   tile_reset,
  output logic                   pll_relocking,
  output logic                   hdr_one_byte,
  output logic                   ctl_write_lock,
  output logic [15:0]            node_id
);

  logic [BOOT_W-1:0] boot_sync;
  logic              lock_sync;

  logic [1:0]        cap_cnt_r;
  logic [1:0]        cap_cnt_nxt;
  logic              cap_done_r;
  logic              cap_done_nxt;
  logic [BOOT_W-1:0] boot_r;
  logic [BOOT_W-1:0] boot_nxt;

  logic              ctl_lock_r;
  logic              ctl_lock_nxt;
  logic              pll_lock_r;
  logic              pll_lock_nxt;
  logic              hdr_r;
  logic              hdr_nxt;
  logic [15:0]       node_id_r;
  logic [15:0]       node_id_nxt;
  ncr_pll_t          pll_r;
  ncr_pll_t          pll_nxt;
  logic              upd_r;
  logic              upd_nxt;

  logic              rsp_valid_r;
  logic              rsp_valid_nxt;
  ncr_rsp_t          rsp_r;
  ncr_rsp_t          rsp_nxt;

  logic              wr;
  logic              rd;
  logic              wr_ok;
  logic              pll_wr;
  ncr_ident_t        ident;
  ncr_pll_t          pll_in;

  ncr_sync2 #(.W(BOOT_W)) u_boot_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d       (boot_select_pins),
    .q       (boot_sync)
  );

  ncr_sync2 #(.W(1)) u_lock_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d       (pll_lock),
    .q       (lock_sync)
  );

  // Writes allowed by the lock bits
  function automatic logic write_allowed(input logic [7:0] num,
                                         input logic ctl_lk,
                                         input logic pll_lk);
    logic ok;
    ok = 1'b0;
    unique case (num)
      REG_SW_CFG:     ok = !ctl_lk;
      REG_NODE_IDENT: ok = !ctl_lk;
      REG_PLL_SET:    ok = !ctl_lk && !pll_lk;
      default:        ok = 1'b0;
    endcase
    return ok;
  endfunction

  assign wr     = req_valid && req.write;
  assign rd     = req_valid && !req.write;
  assign wr_ok  = write_allowed(req.num, ctl_lock_r, pll_lock_r);
  assign pll_wr = wr && wr_ok && (req.num == REG_PLL_SET);
  assign pll_in = ncr_pll_t'(req.wdata & PLL_WMASK);

  // Boot pin capture after reset release
  always_comb begin
    cap_cnt_nxt  = cap_cnt_r;
    cap_done_nxt = cap_done_r;
    boot_nxt     = boot_r;
    if (!cap_done_r) begin
      if (cap_cnt_r == CAP_WAIT) begin
        boot_nxt     = boot_sync;
        cap_done_nxt = 1'b1;
      end else begin
        cap_cnt_nxt = cap_cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cap_cnt_r  <= '0;
      cap_done_r <= 1'b0;
      boot_r     <= '0;
    end else begin
      cap_cnt_r  <= cap_cnt_nxt;
      cap_done_r <= cap_done_nxt;
      boot_r     <= boot_nxt;
    end
  end

  // Register writes
  always_comb begin
    ctl_lock_nxt = ctl_lock_r;
    pll_lock_nxt = pll_lock_r;
    hdr_nxt      = hdr_r;
    node_id_nxt  = node_id_r;
    pll_nxt      = pll_r;
    upd_nxt      = 1'b0;
    if (wr && wr_ok) begin
      unique case (req.num)
        REG_SW_CFG: begin
          ctl_lock_nxt = req.wdata[SWCFG_CTL_LOCK_BIT];
          pll_lock_nxt = req.wdata[SWCFG_PLL_LOCK_BIT];
          hdr_nxt      = req.wdata[SWCFG_HDR_BIT];
        end
        REG_NODE_IDENT: node_id_nxt = req.wdata[15:0];
        REG_PLL_SET: begin
          pll_nxt = pll_in;
          upd_nxt = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctl_lock_r <= 1'b0;
      pll_lock_r <= 1'b0;
      hdr_r      <= 1'b0;
      node_id_r  <= NODE_ID_RST;
      pll_r      <= ncr_pll_t'(PLL_RST);
      upd_r      <= 1'b0;
    end else begin
      ctl_lock_r <= ctl_lock_nxt;
      pll_lock_r <= pll_lock_nxt;
      hdr_r      <= hdr_nxt;
      node_id_r  <= node_id_nxt;
      pll_r      <= pll_nxt;
      upd_r      <= upd_nxt;
    end
  end

  // Tile reset and relock sequencing
  ncr_pll_seq u_seq (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .start      (pll_wr),
    .no_reset   (pll_in.no_reset),
    .no_wait    (pll_in.no_wait),
    .pll_locked (lock_sync),
    .tile_reset (tile_reset),
    .relocking  (pll_relocking)
  );

  // Identity word
  always_comb begin
    ident          = '0;
    ident.boot     = boot_r;
    ident.revision = SW_REVISION;
    ident.version  = SW_VERSION;
  end

  // Response, one cycle after the request
  always_comb begin
    rsp_valid_nxt = req_valid;
    rsp_nxt       = '0;
    if (wr) begin
      rsp_nxt.ack = wr_ok;
    end else if (rd) begin
      rsp_nxt.ack = 1'b1;
      unique case (req.num)
        REG_NODE_ID_WORD: rsp_nxt.rdata = ident;
        REG_SW_DESC:
          rsp_nxt.rdata = {8'h00, NUM_LINKS, NUM_PROCS_SW,
                           NUM_PROCS_DEV};
        REG_SW_CFG: begin
          rsp_nxt.rdata[SWCFG_CTL_LOCK_BIT] = ctl_lock_r;
          rsp_nxt.rdata[SWCFG_PLL_LOCK_BIT] = pll_lock_r;
          rsp_nxt.rdata[SWCFG_HDR_BIT]      = hdr_r;
        end
        REG_NODE_IDENT: rsp_nxt.rdata[15:0] = node_id_r;
        REG_PLL_SET:    rsp_nxt.rdata = pll_r;
        default:        rsp_nxt.ack = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
    end else begin
      rsp_valid_r <= rsp_valid_nxt;
      rsp_r       <= rsp_nxt;
    end
  end

  assign rsp_valid      = rsp_valid_r;
  assign rsp            = rsp_r;
  assign pll_cfg        = pll_r;
  assign pll_update     = upd_r;
  assign hdr_one_byte   = hdr_r;
  assign ctl_write_lock = ctl_lock_r;
  assign node_id        = node_id_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_rsp_one_cycle: assert property (
    req_valid |=> rsp_valid ##1 (rsp_valid == $past(req_valid)))
    else $error("response not one cycle after request");
  a_id_readonly: assert property (
    wr && req.num == REG_NODE_ID_WORD |=> rsp_valid && !rsp.ack)
    else $error("identity write acknowledged");
  a_boot_hold: assert property (
    cap_done_r |=> $stable(boot_r))
    else $error("captured boot pins changed");
  a_desc_read: assert property (
    rd && req.num == REG_SW_DESC |=>
      rsp.rdata[23:16] == NUM_LINKS && rsp.rdata[31:24] == 8'h00)
    else $error("description word wrong");
  a_ctl_lock: assert property (
    ctl_lock_r && wr && req.num == REG_NODE_IDENT |=>
      $stable(node_id_r) && !rsp.ack)
    else $error("write passed control lock");
  a_pll_reject: assert property (
    pll_lock_r && wr && req.num == REG_PLL_SET |=>
      $stable(pll_r) && !pll_update)
    else $error("PLL write passed PLL lock");
  a_hdr_write: assert property (
    wr && wr_ok && req.num == REG_SW_CFG |=>
      hdr_one_byte == $past(req.wdata[SWCFG_HDR_BIT]))
    else $error("header width not updated");
  a_nodeid_rsv: assert property (
    rd && req.num == REG_NODE_IDENT |=>
      rsp.rdata == {16'h0000, node_id_r})
    else $error("node identifier read wrong");
  a_pll_reset: assert property (
    pll_wr && !pll_in.no_reset |=> tile_reset [*8])
    else $error("tile reset not held after PLL write");
  a_pll_noreset: assert property (
    pll_wr && pll_in.no_reset |=> !tile_reset)
    else $error("tile reset despite no-reset bit");
  a_relock_skip: assert property (
    pll_wr && !pll_in.no_reset && pll_in.no_wait |=>
      ##[1:20] !tile_reset)
    else $error("relock wait not skipped");
  a_pll_fields: assert property (
    pll_wr |=> pll_cfg.bypass == $past(req.wdata[29])
      && pll_cfg.rsv22 == 2'h0 && pll_update)
    else $error("PLL settings not applied");
  a_upd_pulse: assert property (
    !pll_wr |=> !pll_update)
    else $error("PLL update not a single pulse");

  c_pll_reset: cover property (pll_wr ##1 tile_reset ##[1:40] !tile_reset);
  c_lock_set: cover property (wr && wr_ok && req.num == REG_SW_CFG
                              ##1 ctl_lock_r);
  c_id_read: cover property (rd && req.num == REG_NODE_ID_WORD
                             ##1 rsp.ack);

endmodule

// [hw/ncr_pkg.sv]
package ncr_pkg;

  // Register numbers
  localparam logic [7:0] REG_NODE_ID_WORD = 8'h00;
  localparam logic [7:0] REG_SW_DESC      = 8'h01;
  localparam logic [7:0] REG_SW_CFG       = 8'h04;
  localparam logic [7:0] REG_NODE_IDENT   = 8'h05;
  localparam logic [7:0] REG_PLL_SET      = 8'h06;

  // Switch configuration fields
  localparam int SWCFG_CTL_LOCK_BIT = 31;
  localparam int SWCFG_PLL_LOCK_BIT = 8;
  localparam int SWCFG_HDR_BIT      = 0;

  // Identity values, arbitrary
  localparam logic [7:0] SW_VERSION  = 8'h01;
  localparam logic [7:0] SW_REVISION = 8'h00;

  // Switch description defaults
  localparam logic [7:0] NUM_LINKS      = 8'h08;
  localparam logic [7:0] NUM_PROCS_SW   = 8'h02;
  localparam logic [7:0] NUM_PROCS_DEV  = 8'h02;

  localparam int          BOOT_W      = 8;
  localparam logic [1:0]  CAP_WAIT    = 2'h2;
  localparam logic [15:0] NODE_ID_RST = 16'h0000;

  // Writable bits of the PLL settings word
  localparam logic [31:0] PLL_WMASK   = 32'hF39F_FF7F;
  localparam logic [31:0] PLL_RST     = 32'h0000_0000;

  // Tile reset hold time
  localparam int TILE_RST_NS = 100;
  localparam int CLK_NS      = 10;
  localparam int TILE_RST_CYC = (TILE_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] TILE_RST_LAST = 8'(TILE_RST_CYC - 1);

  typedef struct packed {
    logic        write;
    logic [7:0]  num;
    logic [31:0] wdata;
  } ncr_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } ncr_rsp_t;

  typedef struct packed {
    logic [7:0]        rsv;
    logic [BOOT_W-1:0] boot;
    logic [7:0]        revision;
    logic [7:0]        version;
  } ncr_ident_t;

  typedef struct packed {
    logic        no_reset;
    logic        no_wait;
    logic        bypass;
    logic        jtag_boot;
    logic [1:0]  rsv27;
    logic [2:0]  out_div;
    logic [1:0]  rsv22;
    logic [12:0] fb_mult;
    logic        rsv7;
    logic [6:0]  in_div;
  } ncr_pll_t;

endpackage

// [hw/ncr_pll_seq.sv]
`timescale 1ns/1ns
module ncr_pll_seq import ncr_pkg::*; (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Accepted PLL write
  input  wire logic start,
  input  wire logic no_reset,
  input  wire logic no_wait,
  // Synced lock indication
  input  wire logic pll_locked,
  // Tile reset and relock status
  output logic      tile_reset,
  output logic      relocking
);

  typedef enum logic [1:0] {S_IDLE, S_HOLD, S_RELOCK} ncr_seq_t;

  ncr_seq_t   state_r;
  ncr_seq_t   state_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       wait_r;
  logic       wait_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    wait_nxt  = wait_r;
    if (start) begin
      cnt_nxt  = '0;
      wait_nxt = !no_wait;
      state_nxt = no_reset ? S_IDLE : S_HOLD;
    end else begin
      unique case (state_r)
        S_IDLE: ;
        S_HOLD: begin
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r == TILE_RST_LAST) begin
            state_nxt = wait_r ? S_RELOCK : S_IDLE;
          end
        end
        S_RELOCK: begin
          if (pll_locked) begin
            state_nxt = S_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_r <= S_IDLE;
      cnt_r   <= '0;
      wait_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      wait_r  <= wait_nxt;
    end
  end

  assign tile_reset = (state_r != S_IDLE);
  assign relocking  = (state_r == S_RELOCK);

endmodule

// [hw/ncr_sync2.sv]
`timescale 1ns/1ns
module ncr_sync2 import ncr_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // Async in, synced out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule
